// [src/sso_overlay.sv]
// serial-message overlay unit of a single-wire sensor transmitter channel, with apb registers
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - length zero sends plain status bits
// - length 1..31 overlays bits 2,3
// - length counts bits and frames per message
// - two 32-bit words feed bit 2, bit 3
// - 8-bit counter counts finished messages
// - words latched at message start
// - channel enable 0 unused, 1 used
// - driver state: level, ls oc, hs oc, error
// - select 0 legacy,1 recommended,2 zero,3 all ones
// - select above three gives crc zero
// - disabled output tristated, enabled output active
module sso_overlay (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // frame encoder handshake
   input wire logic frame_start,
   output sso_pkg::sso_frame_t overlay_send_group,
   // output driver pin and feedback, feedback is asynchronous
   input wire sso_pkg::sso_drv_fb_t drv_fb,
   output logic sent_out_en,
   output logic sent_active,
   // interrupt
   output logic irq
);
   import sso_pkg::*;

   // software-written state
   logic [SSO_LEN_W-1:0] serial_msg_length;   // bits per serial message
   logic channel_enable;                      // channel in use
   logic crc_by_data;                         // 1: select value is the crc itself
   logic [SSO_SEL_W-1:0] crc_select;          // crc mode or crc data
   logic [31:0] overlay_word_b2;              // staged bit-2 word
   logic [31:0] overlay_word_b3;              // staged bit-3 word
   logic [3:0] status_nibble;                 // plain status nibble 0
   logic [SSO_EV_W-1:0] irq_stat;             // sticky events
   logic [SSO_EV_W-1:0] irq_mask;             // enable per event
   // overlay engine state
   // frames are strobes of this same clock, so only the driver feedback below needs a synchroniser
   sso_state_t state;
   logic [31:0] shift_b2;                     // latched bit-2 word
   logic [31:0] shift_b3;                     // latched bit-3 word
   logic [SSO_LEN_W-1:0] bit_idx;             // index of bit being sent
   logic [7:0] serial_msg_done_count;         // completed messages
   logic [3:0] driver_state;                  // reported driver flags
   logic [2:0] fb_meta;                       // synchroniser first stage
   logic [2:0] fb_sync;                       // synchroniser second stage
   // decoded strobes
   logic wr_en;
   logic frame_wr;
   logic frame_ev;
   logic msg_done;
   logic err_now;

   // an apb write takes effect in its access cycle, the edge where pready is high
   assign wr_en = psel & penable & pwrite;
   // a write to the frame offset stands in for the encoder strobe, the data is ignored
   assign frame_wr = wr_en & (paddr == SSO_REG_FRAME);
   // frames only count while the channel is in use
   assign frame_ev = (frame_start | frame_wr) & channel_enable;
   // last bit of a message leaves on this frame: index one in the send state,
   // or the only frame of a one-bit message, which never leaves idle
   assign msg_done = frame_ev & (((state == SSO_ST_SEND) & (bit_idx == SSO_LEN_ONE))
      | ((state == SSO_ST_IDLE) & (serial_msg_length == SSO_LEN_ONE)));
   // either overcurrent counts as a detected error
   assign err_now = fb_sync[1] | fb_sync[2];

   // two-stage synchroniser for the driver feedback pins
   // the first stage may go metastable, so nothing but the second stage reads it
   // the cost is two cycles of delay on every driver flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fb_meta <= 3'h0;
         fb_sync <= 3'h0;
      end else begin
         fb_meta <= {drv_fb.hs_overcurrent, drv_fb.ls_overcurrent, drv_fb.output_level};
         fb_sync <= fb_meta;
      end
   end

   // driver state report; error flag set on any overcurrent
   // level bit is forced low while the channel is off, the pin is not driven then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         driver_state <= 4'h0;
      end else begin
         driver_state <= {err_now, fb_sync[2], fb_sync[1], fb_sync[0] & channel_enable};
      end
   end

   // control registers written by software
   // a nonzero length change applies from the next message; a change to zero mid-message aborts it
   // mask and nibble sit here too, so one write decoder serves them all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_msg_length <= '0;
         channel_enable <= 1'b0;  // default unused
         crc_by_data <= 1'b0;
         crc_select <= '0;
         status_nibble <= 4'h0;
         irq_mask <= '0;
      end else if (wr_en) begin
         case (paddr)
            SSO_REG_CTRL: begin
               serial_msg_length <= pwdata[SSO_CTRL_LEN_LSB +: SSO_LEN_W];
               channel_enable <= pwdata[SSO_CTRL_EN_BIT];
               crc_by_data <= pwdata[SSO_CTRL_CRCSRC_BIT];
               crc_select <= pwdata[SSO_CTRL_SEL_LSB +: SSO_SEL_W];
            end
            SSO_REG_NIBBLE: begin
               status_nibble <= pwdata[3:0];
            end
            SSO_REG_IRQ_MASK: begin
               irq_mask <= pwdata[SSO_EV_W-1:0];
            end
            default: begin
               // other offsets handled elsewhere or ignored
            end
         endcase
      end
   end

   // staged overlay words; software refreshes them after each count step
   // the sequencer reads these only when a message opens, so a write mid-message
   // shapes the next message and never the one in flight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overlay_word_b2 <= 32'h0;
         overlay_word_b3 <= 32'h0;
      end else if (wr_en) begin
         if (paddr == SSO_REG_WORD_B2) begin
            overlay_word_b2 <= pwdata;
         end
         if (paddr == SSO_REG_WORD_B3) begin
            overlay_word_b3 <= pwdata;
         end
      end
   end

   // overlay sequencer: latch words, walk the bit index down per frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SSO_ST_IDLE;
         shift_b2 <= 32'h0;
         shift_b3 <= 32'h0;
         bit_idx <= '0;
      end else begin
         case (state)
            SSO_ST_IDLE: begin
               // length zero keeps the engine parked
               if (frame_ev && serial_msg_length != '0) begin
                  // latch both words as the message opens
                  shift_b2 <= overlay_word_b2;
                  shift_b3 <= overlay_word_b3;
                  bit_idx <= serial_msg_length - 1'b1;
                  // a one-bit message opens and closes in this frame, so it stays idle
                  state <= (serial_msg_length == SSO_LEN_ONE) ? SSO_ST_IDLE : SSO_ST_SEND;
               end
            end
            SSO_ST_SEND: begin
               if (serial_msg_length == '0 || !channel_enable) begin
                  state <= SSO_ST_IDLE;
               end else if (frame_ev) begin
                  // the index stops at one: the frame output reads index minus one,
                  // so this frame carries bit zero and nothing ever reads below it
                  if (bit_idx == SSO_LEN_ONE) begin
                     // back to back: the next message opens in the next frame
                     state <= SSO_ST_IDLE;
                  end else begin
                     bit_idx <= bit_idx - 1'b1;
                  end
               end
            end
            default: begin
               // an illegal code falls back to idle
               state <= SSO_ST_IDLE;
            end
         endcase
      end
   end

   // completion counter; a one-bit message completes in its only frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_msg_done_count <= 8'h0;
      end else if (msg_done) begin
         // plain eight-bit add wraps from the top value back to zero
         serial_msg_done_count <= serial_msg_done_count + 8'h1;
      end
   end

   // frame output: status nibble with overlay and checksum choice
   // msg_start stands for one cycle after the opening frame
   // the nibble holds between frames so the encoder may take it at any time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overlay_send_group <= '0;
      end else begin
         overlay_send_group.msg_start <= frame_ev && state == SSO_ST_IDLE && serial_msg_length != '0;
         if (frame_ev) begin
            if (serial_msg_length == '0) begin
               overlay_send_group.frame_nibble_value <= status_nibble;
            end else if (state == SSO_ST_IDLE) begin
               // first bit comes from the words being latched now, msb of the message first
               overlay_send_group.frame_nibble_value <= {overlay_word_b3[serial_msg_length - 1'b1],
                  overlay_word_b2[serial_msg_length - 1'b1], status_nibble[1:0]};
            end else begin
               overlay_send_group.frame_nibble_value <= {shift_b3[bit_idx - 1'b1],
                  shift_b2[bit_idx - 1'b1], status_nibble[1:0]};
            end
         end
         // checksum choice follows software at all times
         // the checksum engine itself sits in the encoder; only the choice is made here
         if (crc_by_data) begin
            overlay_send_group.crc_kind <= SSO_CRC_FIXED;
            overlay_send_group.crc_nibble <= crc_select;
         end else begin
            case (crc_select)
               SSO_SEL_LEGACY: begin
                  overlay_send_group.crc_kind <= SSO_CRC_LEGACY;
                  overlay_send_group.crc_nibble <= SSO_NIB_ZERO;
               end
               SSO_SEL_RECOMMENDED: begin
                  overlay_send_group.crc_kind <= SSO_CRC_RECOMMENDED;
                  overlay_send_group.crc_nibble <= SSO_NIB_ZERO;
               end
               SSO_SEL_FORCE0: begin
                  overlay_send_group.crc_kind <= SSO_CRC_FIXED;
                  overlay_send_group.crc_nibble <= SSO_NIB_ZERO;
               end
               SSO_SEL_FORCEF: begin
                  overlay_send_group.crc_kind <= SSO_CRC_FIXED;
                  overlay_send_group.crc_nibble <= SSO_NIB_ALL;
               end
               default: begin
                  // out-of-range selection sends a zero checksum
                  overlay_send_group.crc_kind <= SSO_CRC_FIXED;
                  overlay_send_group.crc_nibble <= SSO_NIB_ZERO;
               end
            endcase
         end
      end
   end

   // pin drive: tristate while the channel is off
   // enable and active move together, one cycle after the control write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sent_out_en <= 1'b0;
         sent_active <= 1'b0;
      end else begin
         sent_out_en <= channel_enable;
         sent_active <= channel_enable;
      end
   end

   // sticky events; a set in the clearing cycle wins
   // done follows every counter step, error the synchronised overcurrent level
   // while an overcurrent lasts the error bit stays set, a clear in that time has no effect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= '0;
      end else begin
         for (int i = 0; i < SSO_EV_W; i++) begin
            if ((i == SSO_EV_DONE && msg_done) || (i == SSO_EV_ERR && err_now)) begin
               irq_stat[i] <= 1'b1;
            end else if (wr_en && paddr == SSO_REG_IRQ_STAT && pwdata[i]) begin
               irq_stat[i] <= 1'b0;
            end
         end
      end
   end

   // level interrupt, registered so it leaves a flip-flop
   // one cycle late against the status bits, traded for a clean output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   // apb answer: zero wait states, read data valid in the access phase
   // this works because the read mux below is registered in the setup cycle
   // pslverr is tied low: unmapped offsets read zero and ignore writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // ready rises in the access phase and drops after it
         pready <= psel & ~penable;
         pslverr <= 1'b0;
      end
   end

   // read mux registered at setup so data stands during access
   // a mux loaded in the access cycle would be one edge too late for zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            SSO_REG_CTRL: begin
               prdata <= 32'h0;
               prdata[SSO_CTRL_LEN_LSB +: SSO_LEN_W] <= serial_msg_length;
               prdata[SSO_CTRL_EN_BIT] <= channel_enable;
               prdata[SSO_CTRL_CRCSRC_BIT] <= crc_by_data;
               prdata[SSO_CTRL_SEL_LSB +: SSO_SEL_W] <= crc_select;
            end
            SSO_REG_WORD_B2: prdata <= overlay_word_b2;
            SSO_REG_WORD_B3: prdata <= overlay_word_b3;
            SSO_REG_NIBBLE: prdata <= {28'h0, status_nibble};
            SSO_REG_STATUS: begin
               prdata <= 32'h0;
               prdata[SSO_STAT_CNT_LSB +: 8] <= serial_msg_done_count;
               prdata[SSO_STAT_DRV_LSB +: 4] <= driver_state;
               prdata[SSO_STAT_BITS_LSB +: 2] <= overlay_send_group.frame_nibble_value[3:2];
               prdata[SSO_STAT_ACT_BIT] <= (state == SSO_ST_SEND);
            end
            SSO_REG_IRQ_STAT: prdata <= {{(32-SSO_EV_W){1'b0}}, irq_stat};
            SSO_REG_IRQ_MASK: prdata <= {{(32-SSO_EV_W){1'b0}}, irq_mask};
            default: prdata <= 32'h0;  // unmapped and write-only read zero
         endcase
      end
   end
endmodule

// [src/sso_pkg.sv]
// package of constants, register map and carrier types for the serial-message overlay unit
package sso_pkg;
   // register byte offsets
   localparam logic [7:0] SSO_REG_CTRL = 8'h00;      // enable, crc mode/select, length
   localparam logic [7:0] SSO_REG_WORD_B2 = 8'h04;   // bit-2 overlay word
   localparam logic [7:0] SSO_REG_WORD_B3 = 8'h08;   // bit-3 overlay word
   localparam logic [7:0] SSO_REG_NIBBLE = 8'h0c;    // status nibble 0; crc data sits in the control register
   localparam logic [7:0] SSO_REG_STATUS = 8'h10;    // done count, driver state, overlay bits
   localparam logic [7:0] SSO_REG_FRAME = 8'h14;     // write: frame start strobe
   localparam logic [7:0] SSO_REG_IRQ_STAT = 8'h18;  // sticky events, write one to clear
   localparam logic [7:0] SSO_REG_IRQ_MASK = 8'h1c;  // interrupt mask
   // control field positions
   localparam int SSO_CTRL_LEN_LSB = 0;
   localparam int SSO_LEN_W = 5;
   localparam logic [SSO_LEN_W-1:0] SSO_LEN_ONE = SSO_LEN_W'(1);  // one-bit message, last index in send
   localparam int SSO_CTRL_EN_BIT = 8;
   localparam int SSO_CTRL_CRCSRC_BIT = 9;
   localparam int SSO_CTRL_SEL_LSB = 12;
   localparam int SSO_SEL_W = 4;
   // status field positions
   localparam int SSO_STAT_CNT_LSB = 0;
   localparam int SSO_STAT_DRV_LSB = 8;
   localparam int SSO_STAT_BITS_LSB = 12;
   localparam int SSO_STAT_ACT_BIT = 14;
   // event bit positions
   localparam int SSO_EV_DONE = 0;
   localparam int SSO_EV_ERR = 1;
   localparam int SSO_EV_W = 2;
   // crc select codes and forced nibbles
   localparam logic [3:0] SSO_SEL_LEGACY = 4'h0;
   localparam logic [3:0] SSO_SEL_RECOMMENDED = 4'h1;
   localparam logic [3:0] SSO_SEL_FORCE0 = 4'h2;
   localparam logic [3:0] SSO_SEL_FORCEF = 4'h3;
   localparam logic [3:0] SSO_NIB_ZERO = 4'h0;
   localparam logic [3:0] SSO_NIB_ALL = 4'hf;
   // crc kind fed to the checksum engine
   typedef enum logic [1:0] {
      SSO_CRC_LEGACY = 2'h0,
      SSO_CRC_RECOMMENDED = 2'h1,
      SSO_CRC_FIXED = 2'h2
   } sso_crc_kind_t;
   // overlay state machine, one-hot
   typedef enum logic [1:0] {
      SSO_ST_IDLE = 2'b01,
      SSO_ST_SEND = 2'b10
   } sso_state_t;
   // per-frame output toward the frame encoder
   typedef struct packed {
      logic [3:0] frame_nibble_value;  // status nibble 0 with overlay applied
      sso_crc_kind_t crc_kind;         // how the encoder forms the checksum
      logic [3:0] crc_nibble;          // nibble used when crc_kind is fixed
      logic msg_start;                 // this frame opens a serial message
   } sso_frame_t;
   // driver feedback from the output stage
   typedef struct packed {
      logic hs_overcurrent;
      logic ls_overcurrent;
      logic output_level;
   } sso_drv_fb_t;
endpackage

// [bench/sso_overlay_sva.sv]
// assertion checker bound to the overlay unit ports
`timescale 1ns/1ps
module sso_overlay_sva (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // frame side and pin
   input wire logic frame_start,
   input wire sso_pkg::sso_frame_t overlay_send_group,
   input wire sso_pkg::sso_drv_fb_t drv_fb,
   input wire logic sent_out_en,
   input wire logic sent_active,
   input wire logic irq
);
   import sso_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic frame_req; // frame by strobe or by register write
   assign frame_req = frame_start || (psel && penable && pwrite && paddr == SSO_REG_FRAME);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_no_frame;
      !frame_req;
   endsequence
   a_zero_wait: assert property (s_setup |=> pready) else $error("pready late");
   a_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("pready without setup");
   a_ready_once: assert property (pready |=> !pready) else $error("pready held");
   a_no_slverr: assert property (!pslverr) else $error("pslverr raised");
   a_start_cause: assert property (overlay_send_group.msg_start |-> $past(frame_req && sent_out_en))
      else $error("message start without frame");
   a_nibble_hold: assert property (s_no_frame |=> $stable(overlay_send_group.frame_nibble_value))
      else $error("nibble moved without frame");
   a_pin_pair: assert property (sent_out_en == sent_active) else $error("enable and active differ");
   a_crc_legal: assert property (overlay_send_group.crc_kind != 2'h3) else $error("bad crc kind");
endmodule
bind sso_overlay sso_overlay_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .frame_start, .overlay_send_group, .drv_fb, .sent_out_en, .sent_active, .irq);

// [bench/sso_rx_model.sv]
// far-side receiver model: issues frame strobes and logs every encoded frame
`timescale 1ns/1ps
module sso_rx_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench control, a large gap makes a slow receiver
   input wire logic run,
   input wire logic [3:0] gap,
   // frame interface
   output logic frame_start,
   input wire sso_pkg::sso_frame_t overlay_send_group
);
   import sso_pkg::*;
   logic [3:0] wait_cnt; // idle cycles before the next strobe
   logic took; // a strobe was taken at the last edge
   logic [3:0] nib_q[$]; // received nibbles
   logic ms_q[$]; // received start flags
   // one-cycle strobe, then gap plus one idle cycles; log the answer one edge later
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_start <= 1'b0;
         wait_cnt <= 4'h0;
         took <= 1'b0;
      end else begin
         took <= frame_start;
         if (took) begin
            nib_q.push_back(overlay_send_group.frame_nibble_value);
            ms_q.push_back(overlay_send_group.msg_start);
         end
         if (frame_start) frame_start <= 1'b0;
         else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
         else if (run) begin
            frame_start <= 1'b1;
            wait_cnt <= gap;
         end
      end
   end
endmodule

// [bench/testbench.sv]
// self-checking bench: apb master, reference model and receiver model
`timescale 1ns/1ps
module testbench;
   import sso_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_start, sent_out_en, sent_active, irq, run;
   logic [3:0] gap, nib, en;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, w2, w3, l2, l3; // words written, words latched
   logic em;
   sso_frame_t grp;
   sso_drv_fb_t drv_fb;
   int n_fail, cmp_count, len, pos, cnt, k;
   int lens[4] = '{16, 18, 31, 2};
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   sso_overlay i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .frame_start, .overlay_send_group(grp), .drv_fb, .sent_out_en, .sent_active, .irq);
   sso_rx_model i_rx (.pclk, .presetn, .run, .gap, .frame_start, .overlay_send_group(grp));
   task automatic results();
      if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (t >= 50) n_fail++;
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic ctl(input int l, input logic e, input logic s, input logic [3:0] sel);
      len = l;
      apb(1, SSO_REG_CTRL, {16'h0, sel, 2'b0, s, e, 3'b0, l[4:0]}, rd);
   endtask
   // reference model of one accepted frame, msb first
   task automatic frm(output logic [3:0] xn, output logic xm);
      xm = 1'b0;
      xn = nib;
      if (len != 0) begin
         if (pos == 0) begin
            l2 = w2;
            l3 = w3;
            xm = 1'b1;
         end
         xn = {l3[len-1-pos], l2[len-1-pos], nib[1:0]};
         pos++;
         if (pos == len) begin
            pos = 0;
            cnt = (cnt + 1) % 256;
         end
      end
   endtask
   // frame by register write, answer seen just after the taking edge
   task automatic step();
      apb(1, SSO_REG_FRAME, 0, rd);
      #1;
      frm(en, em);
      chk("nibble", en, grp.frame_nibble_value);
      chk("msg_start", em, grp.msg_start);
   endtask
   task automatic count_chk();
      apb(0, SSO_REG_STATUS, 0, rd);
      chk("count", cnt, rd[7:0]);
   endtask
   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      results();
   end
   initial begin
      {presetn, psel, penable, pwrite, run} = 5'h0;
      {paddr, pwdata, gap, nib, drv_fb} = '0;
      n_fail = 0;
      cmp_count = 0;
      pos = 0;
      cnt = 0;
      void'($urandom(32'h2ac4d2e2));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, SSO_REG_CTRL, 0, rd);
      chk("ctrl reset", 0, rd);
      chk("out_en", 0, sent_out_en);
      count_chk();
      ctl(0, 1, 0, 0);
      for (int i = 0; i < 4; i++) begin
         w2 = $urandom;
         w3 = $urandom;
         nib = 4'($urandom);
         apb(1, SSO_REG_WORD_B2, w2, rd);
         apb(1, SSO_REG_WORD_B3, w3, rd);
         apb(1, SSO_REG_NIBBLE, {28'h0, nib}, rd);
         if (i == 0) step();
         ctl(lens[i], 1, 0, 0);
         for (int j = 0; j < 2 * lens[i]; j++) begin
            if (j == lens[i] / 2) begin
               w2 = $urandom;
               apb(1, SSO_REG_WORD_B2, w2, rd);
            end
            step();
            if (pos == 0) count_chk();
         end
      end
      ctl(2, 0, 0, 0);
      apb(1, SSO_REG_FRAME, 0, rd);
      count_chk();
      chk("out_en off", 0, sent_out_en);
      ctl(1, 1, 0, 0);
      run <= 1'b1;
      k = 0;
      while (i_rx.nib_q.size() < 300 && k < 3000) begin
         @(posedge pclk);
         gap <= 4'($urandom % 4);
         k++;
      end
      run <= 1'b0;
      repeat (20) @(posedge pclk);
      chk("rx frames", 1, i_rx.nib_q.size() >= 300);
      foreach (i_rx.nib_q[i]) begin
         frm(en, em);
         chk("rx nibble", en, i_rx.nib_q[i]);
         chk("rx start", em, i_rx.ms_q[i]);
      end
      count_chk();
      apb(1, SSO_REG_IRQ_MASK, 0, rd);
      apb(1, SSO_REG_IRQ_STAT, 32'h3, rd);
      apb(0, SSO_REG_IRQ_STAT, 0, rd);
      chk("irq stat", 0, rd);
      apb(1, SSO_REG_IRQ_MASK, 32'h1, rd);
      step();
      repeat (2) @(posedge pclk);
      chk("irq on", 1, irq);
      apb(1, SSO_REG_IRQ_MASK, 0, rd);
      repeat (2) @(posedge pclk);
      chk("irq masked", 0, irq);
      apb(1, SSO_REG_IRQ_STAT, 32'h1, rd);
      apb(1, SSO_REG_IRQ_MASK, 32'h1, rd);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 0, irq);
      for (int s = 0; s < 2; s++) begin
         for (int v = 0; v < 16; v++) begin
            ctl(0, 1, s[0], v[3:0]);
            repeat (2) @(posedge pclk);
            if (s == 1 || v > 1) begin
               chk("crc kind", SSO_CRC_FIXED, grp.crc_kind);
               chk("crc nibble", s == 1 ? v : (v == 3 ? 15 : 0), grp.crc_nibble);
            end else chk("crc kind", v, grp.crc_kind);
         end
      end
      drv_fb <= 3'b011;
      repeat (5) @(posedge pclk);
      apb(0, SSO_REG_STATUS, 0, rd);
      chk("drv state", 4'hb, rd[11:8]);
      apb(0, SSO_REG_IRQ_STAT, 0, rd);
      chk("err event", 2, rd & 32'h2);
      drv_fb <= 3'b101;
      ctl(0, 0, 0, 0);
      repeat (5) @(posedge pclk);
      apb(0, SSO_REG_STATUS, 0, rd);
      chk("drv off", 4'hc, rd[11:8]);
      apb(1, 8'h40, 32'hffffffff, rd);
      apb(0, 8'h40, 0, rd);
      chk("unmapped", 0, rd);
      results();
   end
endmodule
